// *** design/aal_pkg.sv ***
package aal_pkg;
  // Operand widths
  localparam int unsigned DATA_W  = 8;
  localparam int unsigned INSN_W  = 14;
  localparam int unsigned FADDR_W = 7;

  // Opcode match masks and values on the 14-bit program word
  localparam logic [13:0] LIT_ADD_MASK = 14'h3E00;
  localparam logic [13:0] LIT_ADD_VAL  = 14'h3E00;
  localparam logic [13:0] REG_ADD_MASK = 14'h3F00;
  localparam logic [13:0] REG_ADD_VAL  = 14'h0700;
  localparam logic [13:0] LIT_AND_MASK = 14'h3F00;
  localparam logic [13:0] LIT_AND_VAL  = 14'h3900;

  // Field positions
  localparam int unsigned DEST_BIT = 7;

  // Reset values
  localparam logic [7:0] ACC_RST  = 8'h00;
  localparam logic       FLAG_RST = 1'b0;

  // Operation kinds
  typedef enum logic [1:0] {
    AAL_OP_NONE    = 2'b00,
    AAL_OP_LIT_ADD = 2'b01,
    AAL_OP_REG_ADD = 2'b10,
    AAL_OP_LIT_AND = 2'b11
  } aal_op_t;
endpackage

// *** design/aal_alu.sv ***
// Overview of operation
// RQ1: Literal add: acc plus literal, all flags
// RQ2: File add: acc plus addressed file register, all flags
// RQ3: Destination bit clear: sum to acc only
// RQ4: Destination bit set: sum to file register, written a cycle later at the address of the following word on file_addr_o
// RQ5: Literal AND into acc, only Z updated
// RQ6: Each instruction commits in one cycle, except a file-destination add, whose file write lands a cycle later
module aal_alu
  import aal_pkg::*;
(
  // Clock and reset
  input  wire logic                 sys_clk_i,
  input  wire logic                 rst_i,
  // Instruction issue
  input  wire logic                 insn_valid_i,
  input  wire logic [INSN_W-1:0]    insn_i,
  // File register read data for the addressed register
  input  wire logic [DATA_W-1:0]    file_rdata_i,
  // File register address and write port
  output logic      [FADDR_W-1:0]   file_addr_o,
  output logic                      file_we_o,
  output logic      [DATA_W-1:0]    file_wdata_o,
  // Working register and flags
  output logic      [DATA_W-1:0]    acc_o,
  output logic                      carry_flag_o,
  output logic                      half_carry_flag_o,
  output logic                      zero_flag_o,
  // Executed-instruction strobe
  output logic                      done_o
);

  aal_op_t             op;
  logic [DATA_W-1:0]   lit;
  logic [DATA_W-1:0]   opnd;
  logic [DATA_W:0]     sum;
  logic [4:0]          low_sum;
  logic [DATA_W-1:0]   result;
  logic                dest_file;
  logic [DATA_W-1:0]   acc_r;
  logic                c_r;
  logic                hc_r;
  logic                z_r;
  logic                we_r;
  logic [DATA_W-1:0]   wdata_r;
  logic                done_r;

  // Opcode decode
  always_comb begin
    op = AAL_OP_NONE;
    if (insn_valid_i) begin
      if ((insn_i & LIT_ADD_MASK) == LIT_ADD_VAL) begin
        op = AAL_OP_LIT_ADD; // RQ1
      end else if ((insn_i & REG_ADD_MASK) == REG_ADD_VAL) begin
        op = AAL_OP_REG_ADD; // RQ2
      end else if ((insn_i & LIT_AND_MASK) == LIT_AND_VAL) begin
        op = AAL_OP_LIT_AND; // RQ5
      end
    end
  end

  assign lit       = insn_i[DATA_W-1:0];
  assign dest_file = insn_i[DEST_BIT];
  // Combinational file address so read data arrives in the same cycle
  assign file_addr_o = insn_i[FADDR_W-1:0]; // RQ2

  // Adder with nibble carry; operand is literal or file data
  always_comb begin
    opnd    = (op == AAL_OP_REG_ADD) ? file_rdata_i : lit;
    sum     = {1'b0, acc_r} + {1'b0, opnd};
    low_sum = {1'b0, acc_r[3:0]} + {1'b0, opnd[3:0]};
    result  = (op == AAL_OP_LIT_AND) ? (acc_r & lit) : sum[DATA_W-1:0];
  end

  // Working register write-back
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      acc_r <= ACC_RST;
    end else begin
      case (op)
        AAL_OP_LIT_ADD: acc_r <= result; // RQ1
        AAL_OP_LIT_AND: acc_r <= result; // RQ5
        AAL_OP_REG_ADD: if (!dest_file) acc_r <= result; // RQ3
        default: acc_r <= acc_r;
      endcase
    end
  end

  // File register write-back
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      we_r    <= 1'b0;
      wdata_r <= ACC_RST;
    end else begin
      we_r    <= (op == AAL_OP_REG_ADD) && dest_file; // RQ4
      wdata_r <= result;
    end
  end

  // Status flags
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      c_r  <= FLAG_RST;
      hc_r <= FLAG_RST;
      z_r  <= FLAG_RST;
    end else begin
      case (op)
        AAL_OP_LIT_ADD, AAL_OP_REG_ADD: begin
          c_r  <= sum[DATA_W]; // RQ1
          hc_r <= low_sum[4];
          z_r  <= (result == '0);
        end
        AAL_OP_LIT_AND: begin
          z_r  <= (result == '0); // RQ5
        end
        default: begin
          z_r <= z_r;
        end
      endcase
    end
  end

  // One-cycle completion strobe
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      done_r <= 1'b0;
    end else begin
      done_r <= (op != AAL_OP_NONE); // RQ6
    end
  end

  assign acc_o             = acc_r;
  assign carry_flag_o      = c_r;
  assign half_carry_flag_o = hc_r;
  assign zero_flag_o       = z_r;
  assign file_we_o         = we_r;
  assign file_wdata_o      = wdata_r;
  assign done_o            = done_r;

  // Literal add: sum and carry checked against the operands before the edge
  property p_lit_add;
    @(posedge sys_clk_i) disable iff (rst_i)
      (op == AAL_OP_LIT_ADD) |=> (acc_o == $past(acc_o + lit))
        && (carry_flag_o == $past(acc_o > ~lit));
  endproperty
  a_lit_add: assert property (p_lit_add) else $error("literal add result wrong"); // RQ1

  // Literal add: nibble carry and zero follow the new sum
  property p_lit_add_hz;
    @(posedge sys_clk_i) disable iff (rst_i)
      (op == AAL_OP_LIT_ADD) |=> (half_carry_flag_o == $past(acc_o[3:0] > ~lit[3:0]))
        && (zero_flag_o == (acc_o == '0));
  endproperty
  a_lit_add_hz: assert property (p_lit_add_hz) else $error("literal add flags wrong"); // RQ1

  // Register add: both carries come from the file operand
  property p_reg_add_hc;
    @(posedge sys_clk_i) disable iff (rst_i)
      (op == AAL_OP_REG_ADD) |=>
        (half_carry_flag_o == $past(acc_o[3:0] > ~file_rdata_i[3:0]))
        && (carry_flag_o == $past(acc_o > ~file_rdata_i));
  endproperty
  a_reg_add_hc: assert property (p_reg_add_hc) else $error("half carry wrong"); // RQ2

  // Register add: zero flag from the sum, whichever destination it takes
  property p_reg_add_z;
    @(posedge sys_clk_i) disable iff (rst_i)
      (op == AAL_OP_REG_ADD) |=> zero_flag_o == $past((acc_o + file_rdata_i) == '0);
  endproperty
  a_reg_add_z: assert property (p_reg_add_z) else $error("register add zero wrong"); // RQ2

  // Destination clear: sum lands in acc, no file write
  property p_dest_acc;
    @(posedge sys_clk_i) disable iff (rst_i)
      (op == AAL_OP_REG_ADD && !dest_file) |=> !file_we_o
        && (acc_o == $past(acc_o + file_rdata_i));
  endproperty
  a_dest_acc: assert property (p_dest_acc) else $error("dest acc wrong"); // RQ3

  // Destination set: sum goes out to the file, acc holds
  property p_dest_file;
    @(posedge sys_clk_i) disable iff (rst_i)
      (op == AAL_OP_REG_ADD && dest_file) |=> file_we_o && $stable(acc_o)
        && (file_wdata_o == $past(acc_o + file_rdata_i));
  endproperty
  a_dest_file: assert property (p_dest_file) else $error("dest file wrong"); // RQ4

  // Literal AND: bitwise result in acc, no file write
  property p_and_result;
    @(posedge sys_clk_i) disable iff (rst_i)
      (op == AAL_OP_LIT_AND) |=> !file_we_o && (acc_o == $past(acc_o & lit));
  endproperty
  a_and_result: assert property (p_and_result) else $error("and result wrong"); // RQ5

  // Literal AND: carries untouched, zero follows the result
  property p_and_flags;
    @(posedge sys_clk_i) disable iff (rst_i)
      (op == AAL_OP_LIT_AND) |=> $stable(carry_flag_o) && $stable(half_carry_flag_o)
        && zero_flag_o == (acc_o == '0);
  endproperty
  a_and_flags: assert property (p_and_flags) else $error("and flags wrong"); // RQ5

  // Completion strobe one cycle after each executed word
  property p_one_cycle;
    @(posedge sys_clk_i) disable iff (rst_i)
      (op != AAL_OP_NONE) |=> done_o ##1 (done_o == $past(op != AAL_OP_NONE));
  endproperty
  a_one_cycle: assert property (p_one_cycle) else $error("completion not in one cycle"); // RQ6

  // Valid low or an unknown word changes nothing and raises no strobe
  property p_refused;
    @(posedge sys_clk_i) disable iff (rst_i)
      (op == AAL_OP_NONE) |=> !done_o && !file_we_o && $stable(acc_o)
        && $stable({carry_flag_o, half_carry_flag_o, zero_flag_o});
  endproperty
  a_refused: assert property (p_refused) else $error("refused word changed state"); // RQ6

  // Main scenarios reached
  c_lit_add: cover property (@(posedge sys_clk_i) disable iff (rst_i) op == AAL_OP_LIT_ADD);
  c_reg_file: cover property (@(posedge sys_clk_i) disable iff (rst_i)
    op == AAL_OP_REG_ADD && dest_file);
  c_and_zero: cover property (@(posedge sys_clk_i) disable iff (rst_i)
    op == AAL_OP_LIT_AND && result == '0);
  c_refused: cover property (@(posedge sys_clk_i) disable iff (rst_i)
    insn_valid_i && op == AAL_OP_NONE);
endmodule

// *** verification/test_add_and_literal_alu_ops.sv ***
module test_add_and_literal_alu_ops;
  timeunit 1ns;
  timeprecision 1ns;
  import aal_pkg::*;
  logic        sys_clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        insn_valid_i = 1'b0;
  logic [13:0] insn_i = 14'h0000;
  logic [7:0]  file_rdata_i = 8'h00;
  logic [6:0]  file_addr_o, wr_addr = 7'h00;
  logic        file_we_o, carry_flag_o, half_carry_flag_o, zero_flag_o, done_o;
  logic [7:0]  file_wdata_o, acc_o;
  logic [7:0]  acc = 8'h00, r = 8'h14;
  logic        c = 1'b0, h = 1'b0, z = 1'b0;
  logic [27:0] exp_q[$];
  logic [13:0] base[8] = '{14'h3E00, 14'h3F00, 14'h0700, 14'h0700,
                           14'h3900, 14'h3900, 14'h0500, 14'h3A00};
  int          n_fail = 0, compares = 0, cyc = 0;
  aal_alu dut (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .insn_valid_i(insn_valid_i),
    .insn_i(insn_i), .file_rdata_i(file_rdata_i), .file_addr_o(file_addr_o),
    .file_we_o(file_we_o), .file_wdata_o(file_wdata_o), .acc_o(acc_o),
    .carry_flag_o(carry_flag_o), .half_carry_flag_o(half_carry_flag_o),
    .zero_flag_o(zero_flag_o), .done_o(done_o));
  // Clock and cycle ceiling
  initial begin
    forever #25 sys_clk_i = ~sys_clk_i;
  end
  always @(posedge sys_clk_i) begin
    wr_addr <= file_addr_o; // Address of the word taken at this edge
    cyc++;
    if (cyc >= 2000) begin
      n_fail++;
      stop_test();
    end
  end
  function automatic logic [7:0] lfsr(input logic [7:0] x);
    return {x[6:0], x[7] ^ x[5] ^ x[4] ^ x[3]};
  endfunction
  task automatic chk(input logic [27:0] got, input logic [27:0] exp);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Drive one program word and note the expected outcome
  task automatic issue(input logic v, input logic [13:0] w, input logic [7:0] rd);
    logic [8:0] s;
    logic [4:0] hs;
    logic [7:0] b, wd;
    logic       dn, we;
    @(negedge sys_clk_i);
    insn_valid_i = v;
    insn_i = w;
    file_rdata_i = rd;
    {dn, we, wd} = 10'h000;
    b = (w[13:12] == 2'b11) ? w[7:0] : rd;
    s = {1'b0, acc} + {1'b0, b};
    hs = {1'b0, acc[3:0]} + {1'b0, b[3:0]};
    if (v && (w & LIT_AND_MASK) == LIT_AND_VAL) begin
      dn = 1;
      acc = acc & b;
      z = (acc == 8'h00);
    end else if (v && ((w & LIT_ADD_MASK) == LIT_ADD_VAL
                 || (w & REG_ADD_MASK) == REG_ADD_VAL)) begin
      {dn, c, h, z} = {1'b1, s[8], hs[4], s[7:0] == 8'h00};
      if (w[13:12] == 2'b00 && w[DEST_BIT]) {we, wd} = {1'b1, s[7:0]};
      else acc = s[7:0];
    end
    // Note only once the design has taken the word, so the watcher never sees it early
    @(posedge sys_clk_i);
    exp_q.push_back({dn, we, w[6:0], wd, acc, c, h, z});
  endtask
  // Compare each settled cycle with the oldest note
  always @(negedge sys_clk_i) begin
    if (!rst_i && exp_q.size() > 0)
      chk({done_o, file_we_o, wr_addr, file_we_o ? file_wdata_o : 8'h00, acc_o, carry_flag_o,
           half_carry_flag_o, zero_flag_o}, exp_q.pop_front());
  end
  // Directed cases, then random words
  initial begin
    repeat (5) @(posedge sys_clk_i);
    #10 rst_i = 0;
    issue(1, 14'h3E10, 8'h00);
    issue(1, 14'h3F15, 8'h00);
    issue(1, 14'h3900, 8'h00);
    issue(1, 14'h3E17, 8'h00);
    issue(1, 14'h0784, 8'hC2);
    issue(1, 14'h077F, 8'hC2);
    issue(1, 14'h3E27, 8'h00);
    issue(0, 14'h3E27, 8'h00);
    issue(1, 14'h3E03, 8'h00);
    issue(1, 14'h395F, 8'h00);
    repeat (300) begin
      r = lfsr(r);
      issue(|r[7:6], base[r[2:0]] | {6'h00, lfsr(r)}, ~r);
    end
    issue(0, 14'h0000, 8'h00);
    repeat (2) @(negedge sys_clk_i);
    if (exp_q.size() != 0) n_fail++; // Unchecked notes count as failures
    stop_test();
  end
  task automatic stop_test();
    $display("Comparisons %0d, mismatches %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
endmodule
